// ---- design/wdt_defs.svh ----
/*
  Constants of the watchdog timer: register offsets, bit positions,
  reset values and timing counts.
  Assumes inclusion by bare name from the package and the testbench.
*/
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// Register offsets on the plain register port
`define WDT_ADDR_CTRL 2'h0
`define WDT_ADDR_COUNT 2'h1
`define WDT_ADDR_CKSEL 2'h2

// Control/status bit positions
`define WDT_B_CTR_GUARD 7
`define WDT_B_CTR_WEN 6
`define WDT_B_CTL_GUARD 5
`define WDT_B_CTL_WEN 4
`define WDT_B_RUN_GUARD 3
`define WDT_B_RUN_EN 2
`define WDT_B_FLAG_GUARD 1
`define WDT_B_FLAG 0

// Clock-select field
`define WDT_CKS_PRE_BIT 3
`define WDT_CKS_RESET 4'hf
`define WDT_CKS_RSVD 4'hf

// Reset, limit and unmapped-read values
`define WDT_COUNT_RESET 8'h00
`define WDT_COUNT_MAX 8'hff
`define WDT_UNMAPPED_READ 8'h00

// Prescaler: first tap divides by 2**6, eight taps, 13-bit divider
`define WDT_PRE_BASE 6
`define WDT_PRE_TAPS 8
`define WDT_PRE_WIDTH 13

// Internal reset length in oscillator cycles, minus one
`define WDT_IRESET_LAST 8'hff

`endif

// ---- design/wdt_pkg.sv ----
/*
  Types of the watchdog timer: register port bundle and state records.
  Assumes wdt_defs.svh on the include path.
*/
`include "wdt_defs.svh"

package wdt_pkg;

  // Register port request from the CPU side
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wdt_bus_t;

  // Whole state of the watchdog core
  typedef struct packed {
    logic [2:0] osc_sync;
    logic [7:0] count;
    logic ctr_wen;
    logic ctl_wen;
    logic run_en;
    logic rst_flag;
    logic [3:0] cks;
    logic [7:0] rdata;
    logic ireset;
    logic [7:0] ireset_cnt;
  } wdt_state_t;

  // Whole state of the prescaler
  typedef struct packed {
    logic [`WDT_PRE_WIDTH-1:0] div;
    logic tick;
  } wdt_pre_state_t;

endpackage

// ---- design/wdt_prescaler.sv ----
/*
  Prescaler of the watchdog: a free divider of the system clock with
  eight taps, phi/64 up to phi/8192, one of which is picked as a tick.
  Assumes a single clock, synchronous active-low reset and a clock enable.
*/
module wdt_prescaler
  import wdt_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Tap choice, 0 means phi/64
  input wire logic [2:0] sel,
  // One-cycle count pulse
  output logic tick
);

  wdt_pre_state_t s_ff; // Registered state
  wdt_pre_state_t nxt_s; // Next state
  logic [`WDT_PRE_TAPS-1:0] tap_hit; // Tap about to roll over

  // One detector per tap: the low bits of the divider all ones
  genvar gi;
  generate
    for (gi = 0; gi < `WDT_PRE_TAPS; gi++)
    begin : g_tap
      assign tap_hit[gi] = &s_ff.div[`WDT_PRE_BASE+gi-1:0];
    end
  endgenerate

  // Divider advance and tick pick
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.div = s_ff.div + `WDT_PRE_WIDTH'(1);
    nxt_s.tick = tap_hit[sel];
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_ff <= '0;
    end
    else if (ce)
    begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;

endmodule

// ---- design/wdt_top.sv ----
/*
  Watchdog timer core: guarded control/status register, 8-bit counter,
  clock-select register, prescaler or oscillator count source, and an
  internal chip reset on counter overflow.
  Assumes one system clock, synchronous active-low reset from the external
  reset pin, a free-running oscillator on a pin, and a CPU that issues
  one-cycle read and write strobes.

  // Summary of operation
  // - Counter write enable needs bit 7 zero
  // - Counter writes only while write enable set
  // - Control write enable needs bit 5 zero
  // - Run and flag writable only when enabled
  // - Run enable needs bit 3 zero
  // - Counter counts while running, else holds
  // - Run enable comes up set
  // - Reset flag needs bit 1 zero
  // - Overflow reset sets reset flag
  // - Pin reset or guarded write clears flag
  // - 8-bit up counter, wrap raises reset
  // - Counter clears to zero on reset
  // - Clock-select upper nibble reads ones
  // - Clock code picks prescaler tap or oscillator
  // - Clock select resets to all ones
  // - Taps phi/64 through phi/8192 in order
  // - Internal reset lasts 256 oscillator cycles
*/
module wdt_top
  import wdt_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire wdt_bus_t bus,
  output logic [7:0] rd_data,
  // Dedicated oscillator pin
  input wire logic osc_clk_pin,
  // Internal chip reset, active high
  output logic chip_reset
);

  wdt_state_t s_ff; // Registered state
  wdt_state_t nxt_s; // Next state

  logic pre_tick; // Prescaler pulse
  logic osc_edge; // Synchronised oscillator rising edge
  logic cnt_event; // Selected count pulse
  logic inc; // Counter advances this cycle
  logic ovf; // Counter wraps this cycle
  logic wr_ctrl; // Write to control/status
  logic wr_count; // Write to counter
  logic wr_cksel; // Write to clock select
  logic [7:0] ctrl_view; // Control/status as read

  // Prescaled system-clock source
  wdt_prescaler u_pre (
    .clk (clk),
    .rst_n (rst_n),
    .ce (ce),
    .sel (s_ff.cks[2:0]),
    .tick (pre_tick)
  );

  // Rising edge seen between the second and third sync stages
  assign osc_edge = s_ff.osc_sync[1] & ~s_ff.osc_sync[2];

  // Count source: top code bit picks prescaler, else oscillator
  assign cnt_event = s_ff.cks[`WDT_CKS_PRE_BIT] ? pre_tick : osc_edge;

  // Address decode of the write strobe
  assign wr_ctrl = bus.wr && (bus.addr == `WDT_ADDR_CTRL);
  assign wr_count = bus.wr && (bus.addr == `WDT_ADDR_COUNT);
  assign wr_cksel = bus.wr && (bus.addr == `WDT_ADDR_CKSEL);

  // Counting stops during the internal reset pulse
  assign inc = s_ff.run_en && cnt_event && !s_ff.ireset;
  // Only a permitted counter write suppresses the wrap; a refused one must not
  assign ovf = inc && (s_ff.count == `WDT_COUNT_MAX) && !(wr_count && s_ff.ctr_wen);

  // Guard bits always read as one
  always_comb
  begin
    ctrl_view = 8'hff;
    ctrl_view[`WDT_B_CTR_WEN] = s_ff.ctr_wen;
    ctrl_view[`WDT_B_CTL_WEN] = s_ff.ctl_wen;
    ctrl_view[`WDT_B_RUN_EN] = s_ff.run_en;
    ctrl_view[`WDT_B_FLAG] = s_ff.rst_flag;
  end

  // Next-state logic of the whole core
  always_comb
  begin
    nxt_s = s_ff;
    // Oscillator pin synchroniser
    nxt_s.osc_sync = {s_ff.osc_sync[1:0], osc_clk_pin};

    // Control/status write; each target judged by its own guard
    if (wr_ctrl)
    begin
      // Software must write the whole byte, guards explicit
      if (!bus.wdata[`WDT_B_CTR_GUARD])
      begin
        nxt_s.ctr_wen = bus.wdata[`WDT_B_CTR_WEN];
      end
      if (!bus.wdata[`WDT_B_CTL_GUARD])
      begin
        nxt_s.ctl_wen = bus.wdata[`WDT_B_CTL_WEN];
      end
      // Uses the enable held before this write
      if (s_ff.ctl_wen && !bus.wdata[`WDT_B_RUN_GUARD])
      begin
        nxt_s.run_en = bus.wdata[`WDT_B_RUN_EN];
      end
      if (s_ff.ctl_wen && !bus.wdata[`WDT_B_FLAG_GUARD])
      begin
        nxt_s.rst_flag = bus.wdata[`WDT_B_FLAG];
      end
    end

    // Counter: a permitted write beats the increment
    if (wr_count && s_ff.ctr_wen)
    begin
      nxt_s.count = bus.wdata;
    end
    else if (inc)
    begin
      nxt_s.count = s_ff.count + 8'h01;
    end

    // Clock select: only the low nibble is stored
    if (wr_cksel)
    begin
      nxt_s.cks = bus.wdata[3:0];
    end

    // Internal reset pulse timed on oscillator edges
    if (s_ff.ireset && osc_edge)
    begin
      if (s_ff.ireset_cnt == `WDT_IRESET_LAST)
      begin
        nxt_s.ireset = 1'b0;
        nxt_s.ireset_cnt = 8'h00;
      end
      else
      begin
        nxt_s.ireset_cnt = s_ff.ireset_cnt + 8'h01;
      end
    end

    // Overflow: chip registers return to reset values, flag is set
    if (ovf)
    begin
      nxt_s.count = `WDT_COUNT_RESET;
      nxt_s.ctr_wen = 1'b0;
      nxt_s.ctl_wen = 1'b0;
      nxt_s.run_en = 1'b1;
      nxt_s.cks = `WDT_CKS_RESET;
      nxt_s.ireset = 1'b1;
      nxt_s.ireset_cnt = 8'h00;
      nxt_s.rst_flag = 1'b1;
    end

    // Read data, valid the cycle after the strobe
    if (bus.rd)
    begin
      unique case (bus.addr)
        `WDT_ADDR_CTRL: nxt_s.rdata = ctrl_view;
        `WDT_ADDR_COUNT: nxt_s.rdata = s_ff.count;
        `WDT_ADDR_CKSEL: nxt_s.rdata = {`WDT_CKS_RSVD, s_ff.cks};
        default: nxt_s.rdata = `WDT_UNMAPPED_READ;
      endcase
    end
  end

  // State register; pin reset wins over the enable
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_ff.osc_sync <= 3'h0;
      s_ff.count <= `WDT_COUNT_RESET;
      s_ff.ctr_wen <= 1'b0;
      s_ff.ctl_wen <= 1'b0;
      s_ff.run_en <= 1'b1;
      s_ff.rst_flag <= 1'b0;
      s_ff.cks <= `WDT_CKS_RESET;
      s_ff.rdata <= 8'h00;
      s_ff.ireset <= 1'b0;
      s_ff.ireset_cnt <= 8'h00;
    end
    else if (ce)
    begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from flip-flops
  assign rd_data = s_ff.rdata;
  assign chip_reset = s_ff.ireset;

  // Guarded counter enable keeps its value on a guard of one
  guard_ctr_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && wr_ctrl && bus.wdata[`WDT_B_CTR_GUARD] && !ovf) |=> $stable(s_ff.ctr_wen))
    else $error("counter enable changed with guard set");

  // Counter ignores writes while locked
  ctr_lock_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && wr_count && !s_ff.ctr_wen && !inc) |=> $stable(s_ff.count))
    else $error("locked counter accepted a write");

  // Guarded control enable takes the written value
  guard_ctl_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && wr_ctrl && !bus.wdata[`WDT_B_CTL_GUARD] && !ovf)
      |=> (s_ff.ctl_wen == $past(bus.wdata[`WDT_B_CTL_WEN])))
    else $error("control enable did not follow guarded write");

  // Run and flag frozen while control writes are disabled
  ctl_lock_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && wr_ctrl && !s_ff.ctl_wen && !ovf) |=> ($stable(s_ff.run_en) && $stable(s_ff.rst_flag)))
    else $error("run or flag changed while locked");

  // Run enable follows a properly guarded write
  run_guard_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && wr_ctrl && s_ff.ctl_wen && !bus.wdata[`WDT_B_RUN_GUARD] && !ovf)
      |=> (s_ff.run_en == $past(bus.wdata[`WDT_B_RUN_EN])))
    else $error("run enable did not follow guarded write");

  // Stopped counter holds without writes
  run_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!s_ff.run_en && !wr_count) |=> $stable(s_ff.count))
    else $error("counter moved while stopped");

  // Reset values of run, counter and clock select
  reset_vals_a: assert property (
    @(posedge clk)
    !rst_n |=> (s_ff.run_en && s_ff.count == 8'h00 && s_ff.cks == 4'hf && !s_ff.rst_flag))
    else $error("wrong values after pin reset");

  // Overflow raises the chip reset and the flag
  ovf_flag_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && ovf) |=> (s_ff.rst_flag && s_ff.ireset && s_ff.count == 8'h00))
    else $error("overflow did not raise reset and flag");

  // Flag holds through the internal reset
  flag_keep_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(s_ff.ireset) |-> s_ff.rst_flag || $past(wr_ctrl))
    else $error("flag lost during internal reset");

  // Internal reset ends only after the last oscillator cycle
  ireset_len_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(s_ff.ireset) |-> $past(s_ff.ireset_cnt) == 8'hff)
    else $error("internal reset pulse length wrong");

  // Guard bits of the control/status register read as ones
  read_ones_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && bus.rd && bus.addr == `WDT_ADDR_CTRL) |=> ((rd_data & 8'haa) == 8'haa))
    else $error("guard bits read as zero");

  // Reserved clock-select nibble reads as ones
  read_rsvd_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && bus.rd && bus.addr == `WDT_ADDR_CKSEL) |=> (rd_data[7:4] == 4'hf))
    else $error("reserved bits read as zero");

  // Frozen enable keeps every state bit
  ce_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(s_ff))
    else $error("state moved with enable low");

  // Oscillator source counts only on synchronised edges
  osc_src_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && !s_ff.cks[`WDT_CKS_PRE_BIT] && !osc_edge && !wr_count) |=> $stable(s_ff.count))
    else $error("counter moved without an oscillator edge");

  // Prescaler source counts only on a tap tick
  pre_src_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && s_ff.cks[`WDT_CKS_PRE_BIT] && !pre_tick && !wr_count) |=> $stable(s_ff.count))
    else $error("counter moved without a tap tick");

  // Overflow brings back run enable and the slowest tap
  ovf_reload_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && ovf) |=> (s_ff.run_en && s_ff.cks == 4'hf))
    else $error("overflow did not reload run and clock select");

  // Chip reset rises only after an overflow
  ireset_src_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(s_ff.ireset) |-> $past(ovf))
    else $error("chip reset without overflow");

endmodule

// ---- tb/wdt_top_tb.sv ----
/*
  Self-checking bench of the watchdog core: guarded control/status
  writes, counter write gating, clock taps, oscillator counting and the
  overflow reset.
  Assumes the design package and header on the include path, a 50 MHz
  clock and the plain one-cycle register port.
*/
`include "wdt_defs.svh"

module wdt_top_tb
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and enable
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  // Register port and pins
  wdt_bus_t bus = '0;
  logic [7:0] rd_data;
  logic osc = 1'b0;
  logic chip_reset;
  // Counters of the run
  int num_errors = 0;
  int cmp_count = 0;

  // System clock, 20 ns period
  always #10 clk = ~clk;

  wdt_top wdt_top_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus), .rd_data(rd_data),
    .osc_clk_pin(osc), .chip_reset(chip_reset));

  // Counts one comparison, reports a mismatch
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rd_data, exp, what);
  endtask

  // One-cycle read strobe, data handed back for a range check
  task automatic rget(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rd_data;
  endtask

  // Oscillator rising edges, slow against the system clock
  task automatic edges(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk);
      osc <= 1'b1;
      repeat (4) @(posedge clk);
      osc <= 0;
    end
  endtask

  // Values straight after reset, unmapped address
  task automatic t_reset();
    rchk(`WDT_ADDR_CTRL, 8'hae, "ctrl reset");
    rchk(`WDT_ADDR_CKSEL, 8'hff, "cksel reset");
    rchk(`WDT_ADDR_COUNT, 8'h00, "count reset");
    wr(2'h3, 8'h5a);
    rchk(2'h3, 8'h00, "unmapped");
    rchk(`WDT_ADDR_CTRL, 8'hae, "ctrl after unmapped");
  endtask

  // Guard bits judged one by one, write gating, stop and hold
  task automatic t_guards();
    wr(`WDT_ADDR_CTRL, 8'hdf);
    rchk(`WDT_ADDR_CTRL, 8'hbe, "ctl enable only");
    wr(`WDT_ADDR_COUNT, 8'h55);
    rchk(`WDT_ADDR_COUNT, 8'h00, "count write refused");
    wr(`WDT_ADDR_CTRL, 8'h5f);
    rchk(`WDT_ADDR_CTRL, 8'hfe, "ctr enable set");
    wr(`WDT_ADDR_CTRL, 8'hf3);
    rchk(`WDT_ADDR_CTRL, 8'hfa, "run stopped");
    wr(`WDT_ADDR_COUNT, 8'h77);
    repeat (9000) @(posedge clk);
    rchk(`WDT_ADDR_COUNT, 8'h77, "count holds");
    wr(`WDT_ADDR_CTRL, 8'hcf);
    wr(`WDT_ADDR_CTRL, 8'hf7);
    rchk(`WDT_ADDR_CTRL, 8'hea, "run refused");
    wr(`WDT_ADDR_CTRL, 8'hdf);
    rchk(`WDT_ADDR_CTRL, 8'hfa, "ctl enable again");
  endtask

  // Prescaler taps: run spans six tick periods plus two cycles, so six or seven counts
  task automatic t_taps();
    int div;
    logic [7:0] v;
    for (int k = 0; k < 6; k++)
    begin
      div = 64 << k;
      wr(`WDT_ADDR_CTRL, 8'hf3);
      wr(`WDT_ADDR_COUNT, 8'h00);
      wr(`WDT_ADDR_CKSEL, 8'h08 + 8'(k));
      rchk(`WDT_ADDR_CKSEL, 8'hf8 + 8'(k), "cksel code");
      wr(`WDT_ADDR_CTRL, 8'hf7);
      repeat (6 * div) @(posedge clk);
      wr(`WDT_ADDR_CTRL, 8'hf3);
      rget(`WDT_ADDR_COUNT, v);
      cmp_count++;
      // Tick phase against the run window allows one extra count
      if ((v !== 8'h06) && (v !== 8'h07))
      begin
        num_errors++;
        $display("mismatch at %0t: tap %0d count %h", $time, k, v);
      end
    end
  endtask

  // Oscillator as count source, then overflow and internal reset
  task automatic t_osc();
    wr(`WDT_ADDR_COUNT, 8'h00);
    wr(`WDT_ADDR_CKSEL, 8'h00);
    wr(`WDT_ADDR_CTRL, 8'hf7);
    edges(10);
    repeat (8) @(posedge clk);
    rchk(`WDT_ADDR_COUNT, 8'h0a, "osc count");
    wr(`WDT_ADDR_COUNT, 8'hfd);
    edges(3);
    repeat (4) @(posedge clk);
    #1 chk({7'h00, chip_reset}, 8'h01, "overflow reset");
    edges(254);
    #1 chk({7'h00, chip_reset}, 8'h01, "reset still on");
    edges(3);
    repeat (8) @(posedge clk);
    #1 chk({7'h00, chip_reset}, 8'h00, "reset ended");
    rchk(`WDT_ADDR_CTRL, 8'haf, "flag set");
    rchk(`WDT_ADDR_CKSEL, 8'hff, "cksel reloaded");
    rchk(`WDT_ADDR_COUNT, 8'h00, "count wrapped");
    wr(`WDT_ADDR_CTRL, 8'hdf);
    wr(`WDT_ADDR_CTRL, 8'hfe);
    rchk(`WDT_ADDR_CTRL, 8'hbf, "flag guarded");
    wr(`WDT_ADDR_CTRL, 8'hfc);
    rchk(`WDT_ADDR_CTRL, 8'hbe, "flag cleared");
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_guards();
    t_taps();
    t_osc();
    report_and_stop();
  end

  // Watchdog of the bench itself
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    $display("mismatch at %0t: run timed out", $time);
    report_and_stop();
  end
endmodule
